//--- logic/pif_irq_flags.v
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pif_regs.vh"
module pif_irq_flags
(
    // Clock and reset
    input wire clk_in,
    input wire resetn_in,
    // Avalon-MM slave
    input wire [9:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Peripheral events
    input wire [7:0] timer2_count_in,
    input wire [7:0] timer2_period_in,
    input wire timer1_wrap_in,
    input wire capcomp2_event_in,
    input wire bus_collision_in,
    input wire i2c_master_mode_in,
    input wire eeprom_write_done_in,
    // Interrupt outputs
    output wire periph_irq_out,
    output wire irq_out
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    reg ack_q;
    wire [7:0] idx = avs_address_in[9:2];
    wire req = avs_read_in | avs_write_in;
    wire wr = avs_write_in & ack_q & avs_byteenable_in[0];
    wire rd_go = avs_read_in & ~ack_q;
    // Hold one wait cycle, then accept
    assign avs_waitrequest_out = req & ~ack_q;
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    function sel;
        input [7:0] a;
        input [7:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    // ----------------------------------------
    // Enable register two
    // ----------------------------------------
    reg [7:0] en2_q;
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            en2_q <= `PIF_RST_BYTE;
        else if (wr && sel(idx, `PIF_IDX_ENABLE_TWO))
            en2_q <= avs_writedata_in[7:0] & `PIF_EN2_WMASK;
    end

    // ----------------------------------------
    // Event detection
    // ----------------------------------------
    reg t2_eq_q;
    wire t2_eq = (timer2_count_in == timer2_period_in);
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            t2_eq_q <= 1'b0;
        else
            t2_eq_q <= t2_eq;
    end
    // Flag on entry to match, regardless of enables
    wire [7:0] set1 = {6'h00, t2_eq & ~t2_eq_q, timer1_wrap_in};
    wire [7:0] set2 = {3'h0, eeprom_write_done_in, bus_collision_in & i2c_master_mode_in,
                       2'h0, capcomp2_event_in};

    // ----------------------------------------
    // Flag registers
    // ----------------------------------------
    wire [7:0] wr_flg1 = (wr && sel(idx, `PIF_IDX_FLAGS_ONE)) ? 8'hFF : 8'h00;
    wire [7:0] wr_flg2 = (wr && sel(idx, `PIF_IDX_FLAGS_TWO)) ? `PIF_FLG2_MASK : 8'h00;
    wire [7:0] flg1;
    wire [7:0] flg2;
    // Software clears by writing zero
    pif_sticky #(.W(8)) u_flg1
    (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .set_in(set1 & 8'h03),
        .clr_in(wr_flg1 & ~avs_writedata_in[7:0] & 8'h03),
        .flag_out(flg1)
    );
    pif_sticky #(.W(8)) u_flg2
    (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .set_in(set2),
        .clr_in(wr_flg2 & ~avs_writedata_in[7:0]),
        .flag_out(flg2)
    );

    // Request to global enable logic
    assign periph_irq_out = |(flg2 & en2_q & `PIF_FLG2_MASK);

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    reg [7:0] imask_q;
    wire [7:0] ist;
    wire [7:0] ev = {3'h0, set2[`PIF_BIT_EEWR], set2[`PIF_BIT_BUSCOL], set2[`PIF_BIT_CCP2], set1[1:0]};
    wire [7:0] wr_ist = (wr && sel(idx, `PIF_IDX_IRQ_STATUS)) ? avs_writedata_in[7:0] : 8'h00;
    pif_sticky #(.W(8)) u_ist
    (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .set_in(ev),
        .clr_in(wr_ist & 8'h1F),
        .flag_out(ist)
    );
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            imask_q <= `PIF_RST_BYTE;
        else if (wr && sel(idx, `PIF_IDX_IRQ_MASK))
            imask_q <= avs_writedata_in[7:0] & 8'h1F;
    end
    assign irq_out = |(ist & imask_q);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (rd_go)
        begin
            case (idx)
                `PIF_IDX_FLAGS_ONE: avs_readdata_out <= {24'h00_0000, flg1};
                `PIF_IDX_ENABLE_TWO: avs_readdata_out <= {24'h00_0000, en2_q};
                `PIF_IDX_FLAGS_TWO: avs_readdata_out <= {24'h00_0000, flg2};
                `PIF_IDX_IRQ_STATUS: avs_readdata_out <= {24'h00_0000, ist};
                `PIF_IDX_IRQ_MASK: avs_readdata_out <= {24'h00_0000, imask_q};
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule // pif_irq_flags
`default_nettype wire

//--- logic/pif_regs.vh
// Summary of operation
// - Timer-2 period match sets flag bit one
// - Timer-1 overflow sets flag bit zero
// - Second enable register sits at 8Dh
// - Enable bit three gates bus collision interrupt
// - Enable bit zero gates capture/compare-2 interrupt
// - Bits 7,5,2,1 read zero, ignore writes
// - Flags set regardless of any enable
// - I2C master collision sets bus collision flag
`ifndef PIF_REGS_VH
`define PIF_REGS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PIF_IDX_FLAGS_ONE 8'h0C
`define PIF_IDX_ENABLE_TWO 8'h8D
`define PIF_IDX_FLAGS_TWO 8'h0D
`define PIF_IDX_IRQ_STATUS 8'hF0
`define PIF_IDX_IRQ_MASK 8'hF1
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIF_BIT_T1_OVF 0
`define PIF_BIT_T2_MATCH 1
`define PIF_BIT_CCP2 0
`define PIF_BIT_BUSCOL 3
`define PIF_BIT_EEWR 4
`define PIF_BIT_RSVD6 6
`define PIF_EN2_WMASK 8'h59
`define PIF_FLG2_MASK 8'h19
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIF_RST_BYTE 8'h00
`endif

//--- logic/pif_sticky.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Sticky flag bank: set wins over clear
// ----------------------------------------
module pif_sticky
#(
    parameter W = 8
)
(
    // Clock and reset
    input wire clk_in,
    input wire resetn_in,
    // Set and clear
    input wire [W-1:0] set_in,
    input wire [W-1:0] clr_in,
    // State
    output wire [W-1:0] flag_out
);
    reg [W-1:0] flag_q;
    genvar i;
    // One flop per bit
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    flag_q[i] <= 1'b0;
                else if (set_in[i])
                    flag_q[i] <= 1'b1;
                else if (clr_in[i])
                    flag_q[i] <= 1'b0;
            end
        end
    endgenerate
    assign flag_out = flag_q;
endmodule // pif_sticky
`default_nettype wire

//--- test/pif_irq_flags_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Bus timing and interrupt cause checks
module pif_irq_flags_chk (
    // Clock and bus
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Events and requests
    input wire logic [7:0] timer2_count_in,
    input wire logic [7:0] timer2_period_in,
    input wire logic timer1_wrap_in,
    input wire logic capcomp2_event_in,
    input wire logic bus_collision_in,
    input wire logic i2c_master_mode_in,
    input wire logic eeprom_write_done_in,
    input wire logic periph_irq_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_wait1; $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out; endproperty
    a_wait1: assert property (p_wait1) else $error("no wait cycle");
    property p_wait2; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_wait2: assert property (p_wait2) else $error("wait too long");
    property p_rd8d; avs_read_in && !avs_waitrequest_out && avs_address_in == 10'h234
        |-> (avs_readdata_out & 32'hFFFF_FFA6) == 0; endproperty
    a_rd8d: assert property (p_rd8d) else $error("unused enable bit set");
    property p_rdf1; avs_read_in && !avs_waitrequest_out && avs_address_in == 10'h030
        |-> (avs_readdata_out & 32'hFFFF_FFFC) == 0; endproperty
    a_rdf1: assert property (p_rdf1) else $error("unused flag bit set");
    property p_hold; !avs_read_in |=> $stable(avs_readdata_out); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rise; $rose(irq_out) |-> $past(timer1_wrap_in || capcomp2_event_in || eeprom_write_done_in
        || bus_collision_in || timer2_count_in == timer2_period_in || avs_write_in); endproperty
    a_rise: assert property (p_rise) else $error("irq without cause");
    property p_prise; $rose(periph_irq_out) |-> $past(avs_write_in || capcomp2_event_in
        || eeprom_write_done_in || bus_collision_in && i2c_master_mode_in); endproperty
    a_prise: assert property (p_prise) else $error("request without cause");
    property p_fall; $fell(irq_out) |-> $past(avs_write_in); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule // pif_irq_flags_chk
bind pif_irq_flags pif_irq_flags_chk u_chk (.*);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0, timer1_wrap_in = 0;
    logic capcomp2_event_in = 0, bus_collision_in = 0, i2c_master_mode_in = 0, eeprom_write_done_in = 0;
    logic [9:0] avs_address_in = 0;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out;
    logic [3:0] avs_byteenable_in = 0;
    logic [7:0] timer2_count_in = 1, timer2_period_in = 0, en2 = 0, fl1 = 0, fl2 = 0, st = 0, mk = 0;
    logic [7:0] wi = 0, wd = 0;
    logic avs_waitrequest_out, periph_irq_out, irq_out;
    logic [7:0] idx_tab [6] = '{8'h0C, 8'h8D, 8'h0D, 8'hF0, 8'hF1, 8'h55};
    int fail_count = 0, num_checks = 0;
    pif_irq_flags uut (.*);
    // Clock
    initial forever #10 clk_in = ~clk_in;
    // Compare and count
    task ck(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // Model read value
    function logic [7:0] mdl(input logic [7:0] i);
        case (i)
            8'h0C: mdl = fl1;
            8'h8D: mdl = en2;
            8'h0D: mdl = fl2;
            8'hF0: mdl = st;
            8'hF1: mdl = mk;
            default: mdl = 0;
        endcase
    endfunction
    // One bus cycle, held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] b);
        int n;
        n = 0;
        avs_address_in <= {i, 2'b00};
        avs_writedata_in <= {24'h0, d};
        avs_byteenable_in <= b;
        avs_read_in <= !w;
        avs_write_in <= w;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0 && ++n < 100);
        if (avs_waitrequest_out !== 1'b0) ck("waitrequest", 32'h0, {31'h0, avs_waitrequest_out});
        if (!w) ck("readdata", {24'h0, mdl(i)}, avs_readdata_out);
        else if (b[0])
        begin
            case (i)
                8'h0C: fl1 &= d;
                8'h8D: en2 = d & 8'h59;
                8'h0D: fl2 &= d;
                8'hF0: st &= ~d;
                8'hF1: mk = d & 8'h1F;
                default: ;
            endcase
        end
        avs_read_in <= 0;
        avs_write_in <= 0;
        @(posedge clk_in);
    endtask
    // Interrupt outputs against model
    task irqs;
        @(negedge clk_in);
        ck("periph_irq", {31'h0, |(fl2 & en2)}, {31'h0, periph_irq_out});
        ck("irq", {31'h0, |(st & mk)}, {31'h0, irq_out});
        @(posedge clk_in);
    endtask
    // One event pulse
    task pulse(input int k, input logic m);
        i2c_master_mode_in <= m;
        if (k == 1) timer2_count_in <= timer2_period_in;
        else {eeprom_write_done_in, bus_collision_in, capcomp2_event_in, timer1_wrap_in} <= 4'b0001 << (k > 1 ? k - 1 : 0);
        @(posedge clk_in);
        {eeprom_write_done_in, bus_collision_in, capcomp2_event_in, timer1_wrap_in} <= 4'b0000;
        timer2_count_in <= timer2_period_in + 8'h01;
        if (k < 2) fl1[k] = 1'b1;
        if (k == 2) fl2[0] = 1'b1;
        if (k == 3 && m) fl2[3] = 1'b1;
        if (k == 4) fl2[4] = 1'b1;
        if (k != 3 || m) st[k] = 1'b1;
        @(posedge clk_in);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        report_and_stop;
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h357d));
        repeat (16) @(posedge clk_in);
        resetn_in <= 1;
        @(posedge clk_in);
        for (int j = 0; j < 60; j++)
        begin
            foreach (idx_tab[x]) bus(1'b0, idx_tab[x], 8'h00, 4'h0);
            pulse($urandom % 5, 1'($urandom));
            irqs;
            wi = idx_tab[$urandom % 6];
            wd = 8'($urandom);
            // Software keeps bit 7 of a first flag register write and bit 6 of an enable two write clear
            if (wi == 8'h0C) wd[7] = 1'b0;
            if (wi == 8'h8D) wd[6] = 1'b0;
            bus(1'b1, wi, wd, 4'($urandom));
            irqs;
        end
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
